// [iot_pkg.sv]
package iot_pkg;
  // register byte offsets on the bus
  localparam logic [3:0] FAST_OSC_TRIM_OFS = 4'h0;
  localparam logic [3:0] SLOW_OSC_TRIM_OFS = 4'h4;
  localparam logic [3:0] PIN_MODE_OFS = 4'h8;
  localparam logic [3:0] SETTLE_STAT_OFS = 4'hc;
  // field positions
  localparam int TRIM_HI = 5;
  localparam int TRIM_LO = 0;
  localparam int SLOW_SEL_BIT = 7;
  // writable masks: unimplemented bits stay zero
  localparam logic [7:0] FAST_TRIM_MASK = 8'h3f;
  localparam logic [7:0] SLOW_TRIM_MASK = 8'hbf;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  // pin mode encodings
  localparam logic [1:0] PIN_MODE_OFF = 2'h0;
  localparam logic [1:0] PIN_MODE_CLKOUT = 2'h1;
  localparam logic [1:0] PIN_MODE_DUAL_IO = 2'h2;
  // settling time
  localparam int CLK_MHZ = 200;
  localparam int SETTLE_US = 100;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [iot_settle_if.sv]
`timescale 1ns/100ps
interface iot_settle_if;
  logic start;
  logic busy;
  modport owner (output start, input busy);
  modport timer (input start, output busy);
endinterface

// [iot_settle.sv]
`timescale 1ns/100ps
module iot_settle #(
  parameter int CYCLES = 20000
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  iot_settle_if.timer sif
);
  logic [31:0] cnt_q;
  logic busy_q;
  assign sif.busy = busy_q;
  // a new write restarts the window; the analog side keeps moving meanwhile
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt_q <= 32'h0;
      busy_q <= 1'b0;
    end else if (sif.start) begin
      cnt_q <= 32'(CYCLES - 1);
      busy_q <= 1'b1;
    end else if (cnt_q != 32'h0) begin
      cnt_q <= cnt_q - 32'h1;
    end else begin
      busy_q <= 1'b0;
    end
  end
endmodule

// [iot_osc_tune.sv]
// Overview of operation
// R1: clock-out mode drives output pin with system clock over four; input pin is port A7.
// R2: dual-I/O mode frees both pins as port A bits seven and six.
// R3: fast oscillator trim comes from fast trim register bits five down to one.
// R4: fast trim bit zero is read/write with no effect on either oscillator.
// R5: fast trim write retunes both oscillators within 100 us without stalling.
// R6: no flag or event marks a retuning shift; consumers just follow. Here settling outputs and SETTLE_STAT_OFS bits flag each window.
// R7: trim fields are signed; 011111 max, 000000 centre, 100000 min.
// R8: select clear: slow oscillator trimmed from fast trim register field.
// R9: select set: slow trim from slow register bits five to one only.
// R10: slow trim bit zero is read/write with no effect on slow oscillator.
// R11: slow trim write retunes slow oscillator within 100 us, no stall.
// R12: fast bits seven, six and slow bit six read zero, ignore writes.
// R13: reset clears both tuning registers, centre frequency, main register selected.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module iot_osc_tune #(
  parameter int SETTLE_CNT = iot_pkg::SETTLE_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trim codes to the analog oscillators
  output logic [4:0] fast_internal_osc_trim_o,
  output logic [4:0] slow_internal_osc_trim_o,
  // settling windows, informative only
  output logic fast_settling_o,
  output logic slow_settling_o,
  // oscillator pins and port a
  input wire logic sys_clk_div4_i,
  input wire logic port_a_bit_seven_out_i,
  input wire logic port_a_bit_seven_oe_i,
  input wire logic port_a_bit_six_out_i,
  input wire logic port_a_bit_six_oe_i,
  input wire logic osc_input_pin_i,
  input wire logic osc_output_pin_i,
  output logic osc_input_pin_o,
  output logic osc_input_pin_oe_o,
  output logic osc_output_pin_o,
  output logic osc_output_pin_oe_o,
  output logic port_a_bit_seven_in_o,
  output logic port_a_bit_six_in_o
);
  import iot_pkg::*;

  typedef enum logic [1:0] {WR_IDLE, WR_RESP} iot_wr_state_type;

  logic [7:0] fast_osc_trim_q;
  logic [7:0] slow_osc_trim_q;
  logic [1:0] pin_mode_q;
  logic have_aw_q;
  logic have_w_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  iot_wr_state_type wr_state_q;
  logic wr_fire;
  logic wr_ok;
  logic fast_hit;
  logic slow_hit;
  logic mode_hit;
  logic [4:0] fast_trim_d;
  logic [4:0] slow_trim_d;
  logic [31:0] rd_data_d;
  logic rd_ok_d;
  logic busy_fast;
  logic busy_slow;
  logic fast_start;
  logic slow_start;

  iot_settle_if fast_sif ();
  iot_settle_if slow_sif ();

  function automatic logic [7:0] apply_strobe(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic lane0,
                                              input logic [7:0] mask);
    apply_strobe = lane0 ? (new_v & mask) : old_v;
  endfunction

  // registers are whole words; the low address bits select nothing
  function automatic logic [3:0] word_addr(input logic [3:0] byte_addr);
    word_addr = {byte_addr[3:2], 2'b00};
  endfunction

  // signed trim field, bits five down to one
  function automatic logic [4:0] trim_code(input logic [7:0] reg_v);
    trim_code = reg_v[TRIM_HI:TRIM_LO + 1];
  endfunction

  // write channel: address and data accepted in either order
  assign wr_fire = have_aw_q && have_w_q && (wr_state_q == WR_IDLE);
  assign fast_hit = wr_fire && (aw_addr_q == FAST_OSC_TRIM_OFS);
  assign slow_hit = wr_fire && (aw_addr_q == SLOW_OSC_TRIM_OFS);
  assign mode_hit = wr_fire && (aw_addr_q == PIN_MODE_OFS);
  assign wr_ok = fast_hit || slow_hit || mode_hit || (aw_addr_q == SETTLE_STAT_OFS);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      have_aw_q <= 1'b0;
      aw_addr_q <= 4'h0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      have_aw_q <= 1'b1;
      aw_addr_q <= word_addr(s_axi_awaddr);
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      have_aw_q <= 1'b0;
    end else begin
      s_axi_awready <= !have_aw_q && (wr_state_q == WR_IDLE);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      have_w_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      have_w_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      have_w_q <= 1'b0;
    end else begin
      s_axi_wready <= !have_w_q && (wr_state_q == WR_IDLE);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_state_q <= WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      case (wr_state_q)
        WR_IDLE: begin
          if (wr_fire) begin
            wr_state_q <= WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
          end
        end
        default: begin
          if (s_axi_bready) begin
            wr_state_q <= WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // tuning registers; masks hold unimplemented bits at zero
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fast_osc_trim_q <= TRIM_RESET; // R13
    end else if (fast_hit) begin
      fast_osc_trim_q <= apply_strobe(fast_osc_trim_q, w_data_q[7:0], w_strb_q[0],
                                      FAST_TRIM_MASK); // R4 R12
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      slow_osc_trim_q <= TRIM_RESET; // R13
    end else if (slow_hit) begin
      slow_osc_trim_q <= apply_strobe(slow_osc_trim_q, w_data_q[7:0], w_strb_q[0],
                                      SLOW_TRIM_MASK); // R10 R12
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pin_mode_q <= PIN_MODE_OFF;
    end else if (mode_hit && w_strb_q[0]) begin
      pin_mode_q <= w_data_q[1:0];
    end
  end

  // bit zero is dropped: two steps of the register make one trim step
  always_comb begin
    fast_trim_d = trim_code(fast_osc_trim_q); // R3 R4 R7
  end

  always_comb begin
    if (slow_osc_trim_q[SLOW_SEL_BIT]) begin
      slow_trim_d = trim_code(slow_osc_trim_q); // R9 R10
    end else begin
      slow_trim_d = trim_code(fast_osc_trim_q); // R8
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fast_internal_osc_trim_o <= 5'h00;
    end else begin
      fast_internal_osc_trim_o <= fast_trim_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      slow_internal_osc_trim_o <= 5'h00;
    end else begin
      slow_internal_osc_trim_o <= slow_trim_d;
    end
  end

  // settling windows never stall the bus and raise no event
  assign fast_start = fast_hit && w_strb_q[0]; // R5
  assign slow_start = fast_start || (slow_hit && w_strb_q[0]); // R5 R11
  assign fast_sif.start = fast_start;
  assign slow_sif.start = slow_start;
  assign busy_fast = fast_sif.busy;
  assign busy_slow = slow_sif.busy;

  iot_settle #(.CYCLES(SETTLE_CNT)) u_fast_settle (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .sif(fast_sif.timer)
  );

  iot_settle #(.CYCLES(SETTLE_CNT)) u_slow_settle (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .sif(slow_sif.timer)
  );

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fast_settling_o <= 1'b0;
    end else begin
      fast_settling_o <= busy_fast; // R6
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      slow_settling_o <= 1'b0;
    end else begin
      slow_settling_o <= busy_slow; // R6
    end
  end

  // pin muxing; in other modes the oscillator owns the pins and nothing is driven
  // oscillator output pin: divided clock, port bit six, or released
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      osc_output_pin_o <= 1'b0;
      osc_output_pin_oe_o <= 1'b0;
    end else if (pin_mode_q == PIN_MODE_CLKOUT) begin
      osc_output_pin_o <= sys_clk_div4_i; // R1
      osc_output_pin_oe_o <= 1'b1; // R1
    end else if (pin_mode_q == PIN_MODE_DUAL_IO) begin
      osc_output_pin_o <= port_a_bit_six_out_i; // R2
      osc_output_pin_oe_o <= port_a_bit_six_oe_i; // R2
    end else begin
      osc_output_pin_o <= 1'b0;
      osc_output_pin_oe_o <= 1'b0;
    end
  end

  // oscillator input pin: port bit seven in both pin modes
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      osc_input_pin_o <= 1'b0;
      osc_input_pin_oe_o <= 1'b0;
    end else if ((pin_mode_q == PIN_MODE_CLKOUT) || (pin_mode_q == PIN_MODE_DUAL_IO)) begin
      osc_input_pin_o <= port_a_bit_seven_out_i; // R1 R2
      osc_input_pin_oe_o <= port_a_bit_seven_oe_i; // R1 R2
    end else begin
      osc_input_pin_o <= 1'b0;
      osc_input_pin_oe_o <= 1'b0;
    end
  end

  // read-back stays zero while the oscillator owns a pin
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      port_a_bit_seven_in_o <= 1'b0;
      port_a_bit_six_in_o <= 1'b0;
    end else if (pin_mode_q == PIN_MODE_CLKOUT) begin
      port_a_bit_seven_in_o <= osc_input_pin_i; // R1
      port_a_bit_six_in_o <= 1'b0;
    end else if (pin_mode_q == PIN_MODE_DUAL_IO) begin
      port_a_bit_seven_in_o <= osc_input_pin_i; // R2
      port_a_bit_six_in_o <= osc_output_pin_i; // R2
    end else begin
      port_a_bit_seven_in_o <= 1'b0;
      port_a_bit_six_in_o <= 1'b0;
    end
  end

  // read channel
  always_comb begin
    rd_data_d = 32'h0;
    rd_ok_d = 1'b1;
    if (word_addr(s_axi_araddr) == FAST_OSC_TRIM_OFS) begin
      rd_data_d = {24'h0, fast_osc_trim_q}; // R12
    end else if (word_addr(s_axi_araddr) == SLOW_OSC_TRIM_OFS) begin
      rd_data_d = {24'h0, slow_osc_trim_q}; // R12
    end else if (word_addr(s_axi_araddr) == PIN_MODE_OFS) begin
      rd_data_d = {30'h0, pin_mode_q};
    end else if (word_addr(s_axi_araddr) == SETTLE_STAT_OFS) begin
      rd_data_d = {30'h0, busy_slow, busy_fast};
    end else begin
      rd_ok_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data_d;
      s_axi_rresp <= rd_ok_d ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// [iot_osc_tune_sva.sv]
`timescale 1ns/100ps
module iot_osc_tune_sva (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // bus handshakes
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trims, settling and pins
  input wire logic [4:0] fast_internal_osc_trim_o,
  input wire logic [4:0] slow_internal_osc_trim_o,
  input wire logic fast_settling_o,
  input wire logic slow_settling_o,
  input wire logic port_a_bit_seven_oe_i,
  input wire logic osc_input_pin_oe_o
);
  // cycles since the last write data beat, saturating so old writes never excuse a change
  logic [2:0] wr_age_q;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i)
      wr_age_q <= 3'h7;
    else if (s_axi_wvalid && s_axi_wready)
      wr_age_q <= 3'h0;
    else if (wr_age_q != 3'h7)
      wr_age_q <= wr_age_q + 3'h1;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence wr_take;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  fast_trim_cause_a: assert property ($changed(fast_internal_osc_trim_o) |-> wr_age_q < 3'h4)
    else $error("fast trim moved without a write");
  slow_trim_cause_a: assert property ($changed(slow_internal_osc_trim_o) |-> wr_age_q < 3'h4)
    else $error("slow trim moved without a write");
  settle_cause_a: assert property ($rose(slow_settling_o) |-> wr_age_q < 3'h4)
    else $error("settling window opened without a write");
  write_answer_a: assert property (wr_take |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  read_answer_a: assert property (rd_take |=> s_axi_rvalid ##0 s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or upper bits set");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  pin7_oe_a: assert property (osc_input_pin_oe_o |-> $past(port_a_bit_seven_oe_i))
    else $error("input pin driven without port request");
  fast_settle_cover_a: cover property ($rose(fast_settling_o));
endmodule

// [iot_osc_tune_tb.sv]
`timescale 1ns/100ps
module iot_osc_tune_tb;
  import iot_pkg::*;
  localparam int SETTLE = 20;
  typedef struct {logic [3:0] a; logic [7:0] wd; logic [7:0] rb; logic [4:0] ft; logic [4:0] st;} iot_row_type;
  iot_row_type rows [8] = '{'{4'h0, 8'hff, 8'h3f, 5'h1f, 5'h1f}, '{4'h0, 8'h01, 8'h01, 5'h00, 5'h00},
    '{4'h0, 8'h40, 8'h00, 5'h00, 5'h00}, '{4'h4, 8'h3e, 8'h3e, 5'h00, 5'h00},
    '{4'h4, 8'hff, 8'hbf, 5'h00, 5'h1f}, '{4'h0, 8'h20, 8'h20, 5'h10, 5'h1f},
    '{4'h4, 8'hc0, 8'h80, 5'h10, 5'h00}, '{4'h4, 8'h41, 8'h01, 5'h10, 5'h10}};
  logic clock_i, rst_n_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0] resp_q;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] fast_internal_osc_trim_o, slow_internal_osc_trim_o;
  logic fast_settling_o, slow_settling_o, sys_clk_div4_i, osc_input_pin_i, osc_output_pin_i;
  logic port_a_bit_seven_out_i, port_a_bit_seven_oe_i, port_a_bit_six_out_i, port_a_bit_six_oe_i;
  logic osc_input_pin_o, osc_input_pin_oe_o, osc_output_pin_o, osc_output_pin_oe_o;
  logic port_a_bit_seven_in_o, port_a_bit_six_in_o, clk, dual;
  int err_count = 0;
  int comparisons = 0;
  iot_osc_tune #(.SETTLE_CNT(SETTLE)) u_iot_osc_tune (.clock_i, .rst_n_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fast_internal_osc_trim_o,
    .slow_internal_osc_trim_o, .fast_settling_o, .slow_settling_o, .sys_clk_div4_i,
    .port_a_bit_seven_out_i, .port_a_bit_seven_oe_i, .port_a_bit_six_out_i, .port_a_bit_six_oe_i,
    .osc_input_pin_i, .osc_output_pin_i, .osc_input_pin_o, .osc_input_pin_oe_o, .osc_output_pin_o,
    .osc_output_pin_oe_o, .port_a_bit_seven_in_o, .port_a_bit_six_in_o);
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp_q[3:2] = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_q = s_axi_rdata;
    resp_q[1:0] = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    {sys_clk_div4_i, port_a_bit_seven_out_i, port_a_bit_seven_oe_i} = 3'h7;
    {port_a_bit_six_out_i, port_a_bit_six_oe_i, osc_input_pin_i, osc_output_pin_i} = 4'h7;
    rst_n_i = 1'b0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd, 4'hf);
      rd(rows[i].a);
      chk(rd_q === {24'h0, rows[i].rb}, "register read back");
      chk(resp_q === {RESP_OKAY, RESP_OKAY}, "bus response");
      chk(fast_internal_osc_trim_o === rows[i].ft, "fast trim");
      chk(slow_internal_osc_trim_o === rows[i].st, "slow trim");
    end
    wr(4'h0, 8'h3f, 4'h0);
    rd(4'h0);
    chk(rd_q === 32'h20, "write without low lane changed register");
    wr(4'h0, 8'h02, 4'hf);
    @(posedge clock_i);
    chk(fast_settling_o === 1'b1 && slow_settling_o === 1'b1, "fast write settling");
    repeat (SETTLE + 5) @(posedge clock_i);
    chk(fast_settling_o === 1'b0 && slow_settling_o === 1'b0, "settling overran");
    rd(4'hc);
    chk(rd_q === 32'h0, "status after settling");
    wr(4'h4, 8'h84, 4'hf);
    @(posedge clock_i);
    chk(slow_settling_o === 1'b1 && fast_settling_o === 1'b0, "slow write settling");
    rd(4'hc);
    chk(rd_q === 32'h2, "status during slow settling");
    for (int m = 0; m < 4; m++) begin
      port_a_bit_seven_out_i <= m[1];
      port_a_bit_seven_oe_i <= m[1];
      wr(4'h8, 8'(m), 4'hf);
      rd(4'h8);
      chk(rd_q === 32'(m), "pin mode read back");
      repeat (3) @(posedge clock_i);
      clk = (m == 1);
      dual = (m == 2);
      chk(osc_output_pin_oe_o === (clk | dual), "output pin drive");
      if (clk | dual) chk(osc_output_pin_o === clk, "output pin value");
      chk(osc_input_pin_oe_o === ((clk | dual) & m[1]), "input pin drive");
      if (clk | dual) chk(osc_input_pin_o === m[1], "input pin value");
      chk(port_a_bit_seven_in_o === (clk | dual), "port bit seven read");
      chk(port_a_bit_six_in_o === dual, "port bit six read");
    end
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(4'h0);
    chk(rd_q === 32'h0, "fast register after reset");
    rd(4'h4);
    chk(rd_q === 32'h0, "slow register after reset");
    chk(fast_internal_osc_trim_o === 5'h00 && slow_internal_osc_trim_o === 5'h00, "reset trims");
    chk(osc_output_pin_oe_o === 1'b0 && osc_input_pin_oe_o === 1'b0, "pins after reset");
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
endmodule
bind iot_osc_tune iot_osc_tune_sva u_iot_osc_tune_sva (.clock_i, .rst_n_i, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .fast_internal_osc_trim_o, .slow_internal_osc_trim_o,
  .fast_settling_o, .slow_settling_o, .port_a_bit_seven_oe_i, .osc_input_pin_oe_o);
